// >>> mbxcfg_device.sv
`timescale 1ns/1ns
module mbxcfg_device (
  input wire logic sys_clk,
  input wire logic rst,
  mbxcfg_if.device mbx,
  input wire logic [2:0] rx_pending,
  input wire logic [1:0] rx_unit,
  input wire logic program_running,
  input wire logic [5:0] p0_event,
  input wire logic p0_event_valid,
  output logic [2:0] rx_grant,
  output logic [7:0] device_interrupt_status,
  output logic [7:0] control_high_byte,
  output logic [7:0] control_low_byte,
  output logic [8:0] base_priority,
  output logic [23:0] max_message_length
);
  typedef enum logic [1:0] {MBX_STAT, MBX_HI, MBX_LO, MBX_PAR} mbx_rx_t;
  typedef enum logic [2:0] {TX_IDLE, TX_STAT, TX_HI, TX_LO, TX_P1, TX_P2} mbx_tx_t;

  mbx_rx_t rx_q;
  mbx_tx_t tx_q;
  logic [7:0] stat_q, hi_q, lo_q, cnt_q;
  logic [2:0] base_q [3];
  logic [3:0] cur_q [3];
  logic [7:0] maxlen_q [3];
  logic [1:0] rsp_path_q;
  logic rsp_req_q;
  logic [1:0] win;
  logic any;
  logic [3:0] msg_code;
  logic [1:0] path;
  logic is_setup, is_req;

  ////////////////////////////////////////////////////////////////////////////
  // host message decode
  assign path = stat_q[mbxcfg_pkg::PATH_HI:mbxcfg_pkg::PATH_LO];
  assign msg_code = stat_q[5:2];
  // setup codes differ between path 0 and paths 1/2
  assign is_setup = (path == mbxcfg_pkg::PATH0) ? (msg_code == mbxcfg_pkg::SETUP_P0)
                    : (msg_code == mbxcfg_pkg::SETUP_P12);
  assign is_req = (path == mbxcfg_pkg::PATH0) ? (msg_code == mbxcfg_pkg::CFGREQ_P0)
                  : (msg_code == mbxcfg_pkg::CFGREQ_P12);

  // receive sequencer: status, ctrl high, ctrl low, parameters
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_q <= MBX_STAT;
      stat_q <= 8'h00;
      hi_q <= 8'h00;
      lo_q <= 8'h00;
      cnt_q <= 8'h00;
    end else if (mbx.h2d_valid) begin
      if (mbx.h2d_start) begin
        stat_q <= mbx.h2d_byte;
        rx_q <= MBX_HI;
      end else begin
        case (rx_q)
          MBX_HI: begin
            hi_q <= mbx.h2d_byte;
            rx_q <= MBX_LO;
          end
          MBX_LO: begin
            lo_q <= mbx.h2d_byte;
            cnt_q <= 8'h00;
            rx_q <= (mbx.h2d_byte == 8'h00) ? MBX_STAT : MBX_PAR;
          end
          MBX_PAR: begin
            cnt_q <= cnt_q + 8'h01;
            if (cnt_q + 8'h01 >= lo_q) rx_q <= MBX_STAT;
          end
          default: rx_q <= MBX_STAT;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // arbitration among pending receive buffers
  always_comb begin
    win = 2'h0;
    any = 1'b0;
    for (int i = 0; i < 3; i++) begin
      // strict compare keeps the lower path on a tie
      if (rx_pending[i] && (!any || cur_q[i] > cur_q[win])) begin
        win = 2'(i);
        any = 1'b1;
      end
    end
  end

  logic setup_done, setup_len;
  assign setup_done = mbx.h2d_valid && !mbx.h2d_start && rx_q == MBX_LO && is_setup;
  assign setup_len = mbx.h2d_valid && !mbx.h2d_start && rx_q == MBX_PAR && is_setup
                     && cnt_q == 8'h00;

  // base and current priority; a priority change wins over aging
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < 3; i++) begin
      if (rst) begin
        base_q[i] <= (i == 0) ? mbxcfg_pkg::PRIO_RST_P0 : mbxcfg_pkg::PRIO_RST_P12;
        cur_q[i] <= {1'b0, (i == 0) ? mbxcfg_pkg::PRIO_RST_P0 : mbxcfg_pkg::PRIO_RST_P12};
      end else if (setup_done && path == 2'(i) && hi_q[2:0] != mbxcfg_pkg::PRIO_KEEP) begin
        base_q[i] <= hi_q[2:0];
        cur_q[i] <= {1'b0, hi_q[2:0]};
      end else if (any && win == 2'(i)) begin
        cur_q[i] <= {1'b0, base_q[i]};
      end else if (any && rx_pending[i] && cur_q[i] != 4'hf) begin
        cur_q[i] <= cur_q[i] + 4'h1; // saturates, no wrap
      end
    end
  end

  // max message length, only touched when a length parameter arrives
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < 3; i++) begin
      if (rst) begin
        maxlen_q[i] <= (i == 0) ? mbxcfg_pkg::MAXPOS_P0 : mbxcfg_pkg::MAXPOS_P12;
      end else if (setup_len && path == 2'(i)) begin
        if (mbx.h2d_byte > ((i == 0) ? mbxcfg_pkg::MAXPOS_P0 : mbxcfg_pkg::MAXPOS_P12))
          maxlen_q[i] <= (i == 0) ? mbxcfg_pkg::MAXPOS_P0 : mbxcfg_pkg::MAXPOS_P12;
        else
          maxlen_q[i] <= mbx.h2d_byte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // grant and status byte selection
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_grant <= 3'h0;
      device_interrupt_status <= mbxcfg_pkg::BUF_AVAIL;
    end else begin
      rx_grant <= any ? (3'h1 << win) : 3'h0;
      if (p0_event_valid) begin
        // download codes are dropped once the program runs
        if (!(program_running && (p0_event == mbxcfg_pkg::P0_CHIPVER ||
              p0_event == mbxcfg_pkg::P0_KEY || p0_event == mbxcfg_pkg::P0_PROG)))
          device_interrupt_status <= {mbxcfg_pkg::PATH0, p0_event};
      end else if (any) begin
        if (win == mbxcfg_pkg::PATH0)
          device_interrupt_status <= {mbxcfg_pkg::PATH0, mbxcfg_pkg::P0_STAT_EVENT};
        else if (rx_unit == mbxcfg_pkg::UNIT_FRAMER)
          device_interrupt_status <= {win, mbxcfg_pkg::DEV_RX_DATA};
        else
          // other units raise a status event tagged with their source
          device_interrupt_status <= {win, mbxcfg_pkg::DEV_STAT_EVENT, rx_unit};
      end else if (rsp_req_q) begin
        // configuration data from the buffer unit
        device_interrupt_status <= {rsp_path_q, (rsp_path_q == mbxcfg_pkg::PATH0)
          ? mbxcfg_pkg::SETUP_P0 : mbxcfg_pkg::DEV_CFG_DATA, mbxcfg_pkg::UNIT_BUFFER};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration response sender; one request is remembered while busy
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rsp_req_q <= 1'b0;
      rsp_path_q <= 2'h0;
    end else if (mbx.h2d_valid && !mbx.h2d_start && rx_q == MBX_LO && is_req) begin
      rsp_req_q <= 1'b1;
      rsp_path_q <= path;
    end else if (tx_q == TX_IDLE) begin
      rsp_req_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_q <= TX_IDLE;
      mbx.d2h_valid <= 1'b0;
      mbx.d2h_start <= 1'b0;
      mbx.d2h_byte <= 8'h00;
      control_high_byte <= 8'h00;
      control_low_byte <= 8'h00;
    end else begin
      mbx.d2h_valid <= tx_q != TX_IDLE;
      mbx.d2h_start <= tx_q == TX_STAT;
      case (tx_q)
        TX_IDLE: if (rsp_req_q) tx_q <= TX_STAT;
        TX_STAT: begin
          mbx.d2h_byte <= {rsp_path_q, (rsp_path_q == mbxcfg_pkg::PATH0) ? mbxcfg_pkg::SETUP_P0
                           : mbxcfg_pkg::DEV_CFG_DATA, mbxcfg_pkg::UNIT_BUFFER};
          tx_q <= TX_HI;
        end
        TX_HI: begin
          mbx.d2h_byte <= {5'h00, base_q[rsp_path_q]};
          control_high_byte <= {5'h00, base_q[rsp_path_q]};
          tx_q <= TX_LO;
        end
        TX_LO: begin
          mbx.d2h_byte <= mbxcfg_pkg::RESP_PARAMS;
          control_low_byte <= mbxcfg_pkg::RESP_PARAMS;
          tx_q <= TX_P1;
        end
        TX_P1: begin
          mbx.d2h_byte <= maxlen_q[rsp_path_q];
          tx_q <= TX_P2;
        end
        TX_P2: begin
          mbx.d2h_byte <= (rsp_path_q == mbxcfg_pkg::PATH0) ? mbxcfg_pkg::MAXPOS_P0
                          : mbxcfg_pkg::MAXPOS_P12;
          tx_q <= TX_IDLE;
        end
        default: tx_q <= TX_IDLE;
      endcase
    end
  end

  // flat views of per-path settings
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      base_priority <= 9'h000;
      max_message_length <= 24'h000000;
    end else begin
      base_priority <= {base_q[2], base_q[1], base_q[0]};
      max_message_length <= {maxlen_q[2], maxlen_q[1], maxlen_q[0]};
    end
  end
endmodule

// >>> mbxcfg_pkg.sv
package mbxcfg_pkg;
  // status byte fields
  localparam int PATH_HI = 7;
  localparam int PATH_LO = 6;
  localparam logic [1:0] PATH0 = 2'h0;
  localparam logic [1:0] PATH1 = 2'h1;
  localparam logic [1:0] PATH2 = 2'h2;
  // device-originated codes, paths 1 and 2
  localparam logic [5:0] DEV_RX_DATA = 6'h20;
  localparam logic [3:0] DEV_CFG_DATA = 4'h9;
  localparam logic [3:0] DEV_STAT_EVENT = 4'ha;
  localparam logic [3:0] DEV_STAT_INFO = 4'hb;
  localparam logic [7:0] BUF_AVAIL = 8'h00;
  // source units
  localparam logic [1:0] UNIT_BUFFER = 2'h0;
  localparam logic [1:0] UNIT_FRAMER = 2'h1;
  localparam logic [1:0] UNIT_PUMP = 2'h2;
  localparam logic [1:0] UNIT_IOM = 2'h3;
  // path 0 full codes
  localparam logic [5:0] P0_STAT_RESP = 6'h3d;
  localparam logic [5:0] P0_STAT_EVENT = 6'h3e;
  localparam logic [5:0] P0_TIMER = 6'h2a;
  localparam logic [5:0] P0_INVALID = 6'h3f;
  localparam logic [5:0] P0_VERSION = 6'h25;
  localparam logic [5:0] P0_CHIPVER = 6'h15;
  localparam logic [5:0] P0_KEY = 6'h03;
  localparam logic [5:0] P0_PROG = 6'h1f;
  // host message codes (bits 5:2) and unit field (bits 1:0)
  localparam logic [3:0] SETUP_P0 = 4'hf;
  localparam logic [3:0] SETUP_P12 = 4'h9;
  localparam logic [3:0] CFGREQ_P0 = 4'h7;
  localparam logic [3:0] CFGREQ_P12 = 4'h1;
  localparam logic [1:0] P0_BUF_UNIT = 2'h0;
  // priorities and lengths
  localparam logic [2:0] PRIO_KEEP = 3'h0;
  localparam logic [2:0] PRIO_RST_P0 = 3'h5;
  localparam logic [2:0] PRIO_RST_P12 = 3'h4;
  localparam logic [7:0] MAXPOS_P0 = 8'h1d;
  localparam logic [7:0] MAXPOS_P12 = 8'h3d;
  localparam logic [7:0] RESP_PARAMS = 8'h02;
endpackage

// >>> mbxcfg_if.sv
`timescale 1ns/1ns
// byte-serial mailbox: status, ctrl high, ctrl low, then parameters
interface mbxcfg_if;
  logic h2d_valid;
  logic h2d_start;
  logic [7:0] h2d_byte;
  logic d2h_valid;
  logic d2h_start;
  logic [7:0] d2h_byte;
  modport device (input h2d_valid, input h2d_start, input h2d_byte,
                  output d2h_valid, output d2h_start, output d2h_byte);
  modport host (output h2d_valid, output h2d_start, output h2d_byte,
                input d2h_valid, input d2h_start, input d2h_byte);
endinterface

// >>> mbxcfg_host.sv
`timescale 1ns/1ns
// host end: sends setup or request messages, collects the response
module mbxcfg_host (
  input wire logic sys_clk,
  input wire logic rst,
  mbxcfg_if.host mbx,
  input wire logic cmd_valid,
  input wire logic cmd_request,
  input wire logic [1:0] cmd_path,
  input wire logic [2:0] cmd_priority,
  input wire logic cmd_has_length,
  input wire logic [7:0] cmd_length,
  output logic cmd_busy,
  output logic rsp_valid,
  output logic [7:0] rsp_status,
  output logic [2:0] rsp_priority,
  output logic [7:0] rsp_length,
  output logic [7:0] rsp_max_length
);
  typedef enum logic [2:0] {HS_IDLE, HS_STAT, HS_HI, HS_LO, HS_PAR} mbxh_tx_t;
  mbxh_tx_t st_q;
  logic req_q, len_q;
  logic [1:0] path_q;
  logic [2:0] prio_q;
  logic [7:0] want_len_q, rcnt_q, rlen_q;
  logic [1:0] rpos_q;

  ////////////////////////////////////////////////////////////////////////////
  // message sender
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q <= HS_IDLE;
      req_q <= 1'b0;
      len_q <= 1'b0;
      path_q <= 2'h0;
      prio_q <= 3'h0;
      want_len_q <= 8'h00;
      cmd_busy <= 1'b0;
      mbx.h2d_valid <= 1'b0;
      mbx.h2d_start <= 1'b0;
      mbx.h2d_byte <= 8'h00;
    end else begin
      mbx.h2d_valid <= 1'b0;
      mbx.h2d_start <= 1'b0;
      case (st_q)
        HS_IDLE: if (cmd_valid) begin
          req_q <= cmd_request;
          len_q <= cmd_has_length;
          path_q <= cmd_path;
          prio_q <= cmd_priority;
          want_len_q <= cmd_length; // largest length advised for throughput
          cmd_busy <= 1'b1;
          st_q <= HS_STAT;
        end
        HS_STAT: begin
          mbx.h2d_valid <= 1'b1;
          mbx.h2d_start <= 1'b1;
          mbx.h2d_byte <= {path_q, (path_q == mbxcfg_pkg::PATH0)
            ? (req_q ? mbxcfg_pkg::CFGREQ_P0 : mbxcfg_pkg::SETUP_P0)
            : (req_q ? mbxcfg_pkg::CFGREQ_P12 : mbxcfg_pkg::SETUP_P12),
            mbxcfg_pkg::P0_BUF_UNIT};
          st_q <= HS_HI;
        end
        HS_HI: begin
          mbx.h2d_valid <= 1'b1;
          mbx.h2d_byte <= req_q ? 8'h00 : {5'h00, prio_q};
          st_q <= HS_LO;
        end
        HS_LO: begin
          mbx.h2d_valid <= 1'b1;
          mbx.h2d_byte <= (req_q || !len_q) ? 8'h00 : 8'h01;
          st_q <= (req_q || !len_q) ? HS_IDLE : HS_PAR;
          cmd_busy <= !(req_q || !len_q);
        end
        HS_PAR: begin
          mbx.h2d_valid <= 1'b1;
          mbx.h2d_byte <= want_len_q;
          st_q <= HS_IDLE;
          cmd_busy <= 1'b0;
        end
        default: st_q <= HS_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // response receiver; extra trailing parameters are counted and dropped
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rpos_q <= 2'h0;
      rcnt_q <= 8'h00;
      rlen_q <= 8'h00;
      rsp_valid <= 1'b0;
      rsp_status <= 8'h00;
      rsp_priority <= 3'h0;
      rsp_length <= 8'h00;
      rsp_max_length <= 8'h00;
    end else begin
      rsp_valid <= 1'b0;
      if (mbx.d2h_valid) begin
        if (mbx.d2h_start) begin
          rsp_status <= mbx.d2h_byte;
          rpos_q <= 2'h1;
        end else if (rpos_q == 2'h1) begin
          rsp_priority <= mbx.d2h_byte[2:0];
          rpos_q <= 2'h2;
        end else if (rpos_q == 2'h2) begin
          rlen_q <= mbx.d2h_byte;
          rcnt_q <= 8'h00;
          rpos_q <= 2'h3;
          rsp_valid <= mbx.d2h_byte == 8'h00;
        end else if (rpos_q == 2'h3) begin
          if (rcnt_q == 8'h00) rsp_length <= mbx.d2h_byte;
          if (rcnt_q == 8'h01) rsp_max_length <= mbx.d2h_byte;
          rcnt_q <= rcnt_q + 8'h01;
          rsp_valid <= rcnt_q + 8'h01 == rlen_q;
        end
      end
    end
  end
endmodule

// >>> mbxcfg_monitor.sv
`timescale 1ns/1ns
// wire checks on the mailbox link between the host end and the device end
module mbxcfg_monitor (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic h2d_valid,
  input wire logic h2d_start,
  input wire logic [7:0] h2d_byte,
  input wire logic d2h_valid,
  input wire logic d2h_start,
  input wire logic [7:0] d2h_byte
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  // message heads: setup, request and configuration response
  logic h_setup;
  logic h_req;
  logic d_rsp;
  assign h_setup = h2d_valid && h2d_start && (h2d_byte inside {8'h3c, 8'h64, 8'ha4});
  assign h_req = h2d_valid && h2d_start && (h2d_byte inside {8'h1c, 8'h44, 8'h84});
  assign d_rsp = d2h_valid && d2h_start && (d2h_byte inside {8'h3c, 8'h64, 8'ha4});
  // both control bytes follow the status byte without a gap
  sequence hdr_tail_s;
    h2d_valid && !h2d_start ##1 h2d_valid && !h2d_start;
  endsequence
  sequence setup_one_s;
    h_setup ##1 h2d_valid ##1 h2d_valid && h2d_byte == 8'h01;
  endsequence
  // priority is never zero in a response, and two parameters follow
  sequence rsp_ctrl_s;
    d2h_valid && !d2h_start && d2h_byte[7:3] == 5'h00 && d2h_byte[2:0] != 3'h0
    ##1 d2h_valid && d2h_byte == 8'h02;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  host_code_legal_a: assert property (
    h2d_valid && h2d_start |-> h_setup || h_req)
    else $error("host status byte not a setup or request code");
  host_header_a: assert property (
    h2d_valid && h2d_start |=> hdr_tail_s)
    else $error("host header not sent whole");
  req_ctrl_zero_a: assert property (
    h_req |=> h2d_byte == 8'h00 ##1 h2d_byte == 8'h00)
    else $error("request control bytes not zero");
  setup_param_a: assert property (
    setup_one_s |=> h2d_valid && !h2d_start)
    else $error("counted parameter missing");
  setup_prio_a: assert property (
    h_setup |=> h2d_byte[7:3] == 5'h00)
    else $error("setup control high byte out of range");
  req_answer_a: assert property (
    h_req |-> ##[3:9] d_rsp)
    else $error("no configuration response");
  rsp_ctrl_a: assert property (
    d_rsp |=> rsp_ctrl_s)
    else $error("response control bytes wrong");
  rsp_len_max_a: assert property (
    d_rsp |-> ##3 d2h_valid && d2h_byte <= ($past(d2h_byte, 3) == 8'h3c ? 8'h1d : 8'h3d))
    else $error("response length above maximum");
  rsp_len_limit_a: assert property (
    d_rsp |-> ##4 d2h_valid && d2h_byte == ($past(d2h_byte, 4) == 8'h3c ? 8'h1d : 8'h3d))
    else $error("response possible length wrong");
  dev_path_legal_a: assert property (
    d2h_valid && d2h_start |-> d2h_byte[7:6] != 2'h3)
    else $error("device path field illegal");
endmodule

// >>> tb_top.sv
`timescale 1ns/1ns
// host end and device end joined over the mailbox link
module tb_top;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_request = 1'b0;
  logic [1:0] cmd_path = 2'h0;
  logic [2:0] cmd_priority = 3'h0;
  logic cmd_has_length = 1'b0;
  logic [7:0] cmd_length = 8'h00;
  logic cmd_busy, rsp_valid;
  logic [7:0] rsp_status, rsp_length, rsp_max_length, dev_status;
  logic [7:0] dev_ctrl_hi, dev_ctrl_lo;
  logic [2:0] rsp_priority, rx_grant;
  logic [2:0] rx_pending = 3'h0;
  logic [1:0] rx_unit = 2'h0;
  logic program_running = 1'b0;
  logic [5:0] p0_event = 6'h00;
  logic p0_event_valid = 1'b0;
  logic [8:0] base_priority;
  logic [23:0] max_message_length;
  logic [31:0] rsp_seen;
  logic [7:0] hq[$];
  logic [7:0] dq[$];
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  mbxcfg_if mbx();
  mbxcfg_device i_mbxcfg_device (.sys_clk(sys_clk), .rst(rst), .mbx(mbx),
    .rx_pending(rx_pending), .rx_unit(rx_unit), .program_running(program_running),
    .p0_event(p0_event), .p0_event_valid(p0_event_valid), .rx_grant(rx_grant),
    .device_interrupt_status(dev_status), .control_high_byte(dev_ctrl_hi),
    .control_low_byte(dev_ctrl_lo),
    .base_priority(base_priority), .max_message_length(max_message_length));
  mbxcfg_host i_mbxcfg_host (.sys_clk(sys_clk), .rst(rst), .mbx(mbx), .cmd_valid(cmd_valid),
    .cmd_request(cmd_request), .cmd_path(cmd_path), .cmd_priority(cmd_priority),
    .cmd_has_length(cmd_has_length), .cmd_length(cmd_length), .cmd_busy(cmd_busy),
    .rsp_valid(rsp_valid), .rsp_status(rsp_status), .rsp_priority(rsp_priority),
    .rsp_length(rsp_length), .rsp_max_length(rsp_max_length));
  mbxcfg_monitor i_mbxcfg_monitor (.sys_clk(sys_clk), .rst(rst),
    .h2d_valid(mbx.h2d_valid), .h2d_start(mbx.h2d_start), .h2d_byte(mbx.h2d_byte),
    .d2h_valid(mbx.d2h_valid), .d2h_start(mbx.d2h_start), .d2h_byte(mbx.d2h_byte));
  always #4 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////////
  // log link bytes and host responses; cut a hang short after 3000 cycles
  always @(posedge sys_clk) begin
    if (mbx.h2d_valid === 1'b1) hq.push_back(mbx.h2d_byte);
    if (mbx.d2h_valid === 1'b1) dq.push_back(mbx.d2h_byte);
    if (rsp_valid === 1'b1) rsp_seen <= {rsp_status, 5'h00, rsp_priority, rsp_length,
                                         rsp_max_length};
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic test_done();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // inputs move 1 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // one host command, then wait out the whole exchange
  task automatic send(input logic rq, input logic [1:0] p, input logic [2:0] pr,
                      input logic hl, input logic [7:0] len);
    int n;
    hq.delete();
    dq.delete();
    rsp_seen = 32'h0;
    cmd_request = rq;
    cmd_path = p;
    cmd_priority = pr;
    cmd_has_length = hl;
    cmd_length = len;
    cmd_valid = 1'b1;
    tick(1);
    cmd_valid = 1'b0;
    n = 0;
    while (cmd_busy !== 1'b0 && n < 60) begin
      tick(1);
      n++;
    end
    tick(16);
  endtask
  task automatic t_setup(input logic [1:0] p, input logic [2:0] pr, input logic hl,
                         input logic [7:0] len, input logic [7:0] hc, input logic [2:0] bp,
                         input logic [7:0] ml);
    send(1'b0, p, pr, hl, len);
    chk(hq[0], hc, "setup status");
    chk({hq[1], hq[2]}, {5'h00, pr, 7'h00, hl}, "setup ctrl");
    chk(hq.size(), 3 + hl, "setup bytes");
    if (hl) chk(hq[3], len, "setup length");
    chk(base_priority[3*p +: 3], bp, "base prio");
    chk(max_message_length[8*p +: 8], ml, "max len");
  endtask
  task automatic t_req(input logic [1:0] p, input logic [7:0] hc, input logic [7:0] dc,
                       input logic [2:0] pr, input logic [7:0] ml, input logic [7:0] mpos);
    send(1'b1, p, 3'h0, 1'b0, 8'h00);
    chk({hq[0], hq[1], hq[2]}, {hc, 16'h0}, "request bytes");
    chk(hq.size(), 3, "request count");
    chk(dq.size(), 5, "response count");
    chk({dq[0], dq[1], dq[2]}, {dc, 5'h00, pr, 8'h02}, "response head");
    chk({dq[3], dq[4]}, {ml, mpos}, "response params");
    chk(rsp_seen, {dc, 5'h00, pr, ml, mpos}, "host response");
    chk({dev_ctrl_hi, dev_ctrl_lo}, {5'h00, pr, 8'h02}, "device ctrl");
    chk(dev_status, dc, "device status");
  endtask
  // a path-0 event code is posted only where the program state allows it
  task automatic t_event(input logic [5:0] code, input logic run, input logic exp);
    logic hit;
    hit = 1'b0;
    program_running = run;
    p0_event = code;
    p0_event_valid = 1'b1;
    tick(1);
    p0_event_valid = 1'b0;
    repeat (5) begin
      hit = hit | (dev_status === {2'h0, code});
      tick(1);
    end
    chk(hit, exp, "path0 event");
  endtask
  // equal priorities go to path 1 first; aged path 2 must win on the very next cycle,
  // which only holds if the new base reloaded both current priorities
  task automatic t_arb();
    int n;
    send(1'b0, 2'h1, 3'h7, 1'b0, 8'h00);
    send(1'b0, 2'h2, 3'h7, 1'b0, 8'h00);
    rx_unit = 2'h1;
    rx_pending = 3'h6;
    n = 0;
    while (rx_grant === 3'h0 && n < 10) begin
      tick(1);
      n++;
    end
    chk(rx_grant, 3'h2, "tie winner");
    chk(dev_status, 8'h60, "framer data status");
    rx_unit = 2'h2;
    tick(1);
    chk(rx_grant, 3'h4, "aged winner");
    chk(dev_status, 8'haa, "pump event status");
    rx_pending = 3'h0;
    rx_unit = 2'h0;
    tick(4);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge sys_clk);
    #1 rst = 1'b0;
    tick(2);
    chk(base_priority, {3'h4, 3'h4, 3'h5}, "reset prio");
    chk(max_message_length, 24'h3d3d1d, "reset len");
    chk(dev_status, 8'h00, "reset status");
    t_setup(2'h1, 3'h3, 1'b1, 8'h46, 8'h64, 3'h3, 8'h3d);
    t_setup(2'h0, 3'h0, 1'b1, 8'h14, 8'h3c, 3'h5, 8'h14);
    t_setup(2'h0, 3'h6, 1'b0, 8'h00, 8'h3c, 3'h6, 8'h14);
    t_setup(2'h0, 3'h2, 1'b1, 8'h1e, 8'h3c, 3'h2, 8'h1d);
    t_setup(2'h2, 3'h1, 1'b0, 8'h00, 8'ha4, 3'h1, 8'h3d);
    t_req(2'h1, 8'h44, 8'h64, 3'h3, 8'h3d, 8'h3d);
    t_req(2'h0, 8'h1c, 8'h3c, 3'h2, 8'h1d, 8'h1d);
    t_req(2'h2, 8'h84, 8'ha4, 3'h1, 8'h3d, 8'h3d);
    t_arb();
    t_event(mbxcfg_pkg::P0_CHIPVER, 1'b0, 1'b1);
    t_event(mbxcfg_pkg::P0_TIMER, 1'b1, 1'b1);
    t_event(mbxcfg_pkg::P0_INVALID, 1'b1, 1'b1);
    t_event(mbxcfg_pkg::P0_KEY, 1'b1, 1'b0);
    test_done();
  end
endmodule
